/* hw/osc_startup_counter.sv */
// counts oscillator start-up clocks after a power-down wakeup
`timescale 1ns/1ps
`default_nettype none
module osc_startup_counter (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  wake_if.counter   wk
);
  import power_control_pkg::*;

  typedef struct packed {
    logic [STARTUP_CNT_W-1:0] count;
    logic                     busy;
    logic                     done;
  } cnt_s;

  cnt_s cur_ff;
  cnt_s nxt_cur;

  // load on start, count down, pulse done on the last clock
  always_comb begin
    nxt_cur      = cur_ff;
    nxt_cur.done = 1'b0;
    if (wk.start) begin
      nxt_cur.busy  = 1'b1;
      nxt_cur.count = (wk.longCount ? STARTUP_XTAL_CLKS : STARTUP_RC_CLKS) - 11'h1;
    end else if (cur_ff.busy) begin
      if (cur_ff.count == '0) begin
        nxt_cur.busy = 1'b0;
        nxt_cur.done = 1'b1;
      end else begin
        nxt_cur.count = cur_ff.count - 11'h1;
      end
    end
    if (sys_rst) begin
      nxt_cur = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    cur_ff <= nxt_cur;
  end

  assign wk.done = cur_ff.done;
endmodule
`default_nettype wire

/* hw/power_control_pkg.sv */
// constants, types and helpers shared by the power control register design
// ============================================================================
package power_control_pkg;

  // ==========================================================================
  // register map: special function index and its wishbone byte address
  localparam logic [7:0]  CTRL_INDEX       = 8'h87;
  localparam logic [7:0]  IRQ_STATUS_INDEX = 8'hf0;
  localparam logic [7:0]  IRQ_MASK_INDEX   = 8'hf1;
  localparam int          ADDR_W           = 12;

  // ==========================================================================
  // power control field positions
  localparam int BIT_BAUD_DOUBLE    = 7;
  localparam int BIT_SERIAL_B7_SEL  = 6;
  localparam int BIT_BROWNOUT_FLAG  = 5;
  localparam int BIT_POWER_ON_FLAG  = 4;
  localparam int BIT_GENERAL_ONE    = 3;
  localparam int BIT_GENERAL_ZERO   = 2;
  localparam int BIT_POWER_DOWN_CTL = 1;
  localparam int BIT_IDLE_CTL       = 0;

  // ==========================================================================
  // reset values by cause
  localparam logic [7:0] CTRL_RST_POWER_ON = 8'h30;
  localparam logic [7:0] CTRL_RST_BROWNOUT = 8'h20;
  localparam logic [7:0] CTRL_RST_OTHER    = 8'h00;

  // ==========================================================================
  // interrupt status layout
  localparam int         IRQ_W          = 3;
  localparam int         IRQ_BROWNOUT   = 0;
  localparam int         IRQ_IDLE_EXIT  = 1;
  localparam int         IRQ_DOWN_EXIT  = 2;
  localparam logic [2:0] IRQ_MASK_RST   = 3'h0;

  // ==========================================================================
  // oscillator start-up counts in cpu clocks
  localparam int         STARTUP_CNT_W    = 11;
  localparam logic [10:0] STARTUP_XTAL_CLKS = 11'h400;
  localparam logic [10:0] STARTUP_RC_CLKS   = 11'h100;

  // ==========================================================================
  // enumerations
  typedef enum logic [1:0] {
    CAUSE_OTHER    = 2'b00,
    CAUSE_POWER_ON = 2'b01,
    CAUSE_BROWNOUT = 2'b10
  } reset_cause_e;

  typedef enum logic [1:0] {
    PH_RUN  = 2'b00,
    PH_DOWN = 2'b01,
    PH_WARM = 2'b10
  } sleep_phase_e;

  // ==========================================================================
  // helpers
  function automatic logic [ADDR_W-1:0] byteAddr(input logic [7:0] index);
    byteAddr = {2'h0, index, 2'h0};
  endfunction

  function automatic logic [7:0] ctrlResetValue(input reset_cause_e cause);
    case (cause)
      CAUSE_POWER_ON: ctrlResetValue = CTRL_RST_POWER_ON;
      CAUSE_BROWNOUT: ctrlResetValue = CTRL_RST_BROWNOUT;
      default:        ctrlResetValue = CTRL_RST_OTHER;
    endcase
  endfunction

endpackage

/* hw/power_control_register.sv */
// power control register with wishbone slave, power modes and interrupt
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module power_control_register (
  input  wire logic                             ref_clk,
  input  wire logic                             sys_rst,
  // wishbone classic slave
  input  wire logic                             wb_cyc_i,
  input  wire logic                             wb_stb_i,
  input  wire logic                             wb_we_i,
  input  wire logic [power_control_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                       wb_sel_i,
  input  wire logic [31:0]                      wb_dat_i,
  output logic      [31:0]                      wb_dat_o,
  output logic                                  wb_ack_o,
  // reset cause and wakeup sources
  input  wire power_control_pkg::reset_cause_e  resetCause,
  input  wire logic                             brownoutEvent,
  input  wire logic                             wakeIrq,
  input  wire logic                             crystalOsc,
  input  wire logic [1:0]                       serialMode,
  // control outputs toward cpu, oscillator and serial port
  output logic                                  baudDouble,
  output logic                                  serialBit7IsFrameErr,
  output logic                                  idleMode,
  output logic                                  powerDownMode,
  output logic                                  oscRun,
  output logic                                  cpuHold,
  output logic                                  irq
);
  import power_control_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    logic [7:0]       ctrl;
    logic [IRQ_W-1:0] irqStatus;
    logic [IRQ_W-1:0] irqMask;
    sleep_phase_e     phase;
    logic             ack;
    logic [31:0]      rdData;
    logic             wakeStart;
    logic             longCount;
    logic             baudDbl;
    logic             bit7FrameErr;
    logic             idleOut;
    logic             downOut;
    logic             oscOut;
    logic             holdOut;
    logic             irqOut;
  } ctl_s;

  ctl_s st_ff;
  ctl_s nxt_st;

  wake_if wk ();

  osc_startup_counter osc_startup_counter_i (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .wk      (wk.counter)
  );

  assign wk.start     = st_ff.wakeStart;
  assign wk.longCount = st_ff.longCount;

  // ==========================================================================
  // bus decode
  logic req;
  logic wrLane0;
  logic hitCtrl;
  logic hitStatus;
  logic hitMask;

  // a request is taken once, in the cycle before ack rises
  always_comb begin
    req       = wb_cyc_i & wb_stb_i & ~st_ff.ack;
    wrLane0   = req & wb_we_i & wb_sel_i[0];
    hitCtrl   = (wb_adr_i == byteAddr(CTRL_INDEX));
    hitStatus = (wb_adr_i == byteAddr(IRQ_STATUS_INDEX));
    hitMask   = (wb_adr_i == byteAddr(IRQ_MASK_INDEX));
  end

  // ==========================================================================
  // next-state logic
  logic [IRQ_W-1:0] events;

  always_comb begin
    nxt_st           = st_ff;
    events           = '0;
    nxt_st.ack       = req;
    nxt_st.wakeStart = 1'b0;

    // software writes first so that hardware sets below win over a clear
    if (wrLane0 && hitCtrl) begin
      nxt_st.ctrl = wb_dat_i[7:0];
    end
    if (wrLane0 && hitStatus) begin
      nxt_st.irqStatus = st_ff.irqStatus & ~wb_dat_i[IRQ_W-1:0];
    end
    if (wrLane0 && hitMask) begin
      nxt_st.irqMask = wb_dat_i[IRQ_W-1:0];
    end

    // brownout interrupt sets its flag even during a clearing write
    if (brownoutEvent) begin
      nxt_st.ctrl[BIT_BROWNOUT_FLAG] = 1'b1;
      events[IRQ_BROWNOUT]           = 1'b1;
    end

    // idle ends on any wakeIrq, which irqMask does not gate; power-down has priority over idle
    if (st_ff.ctrl[BIT_IDLE_CTL] && !st_ff.ctrl[BIT_POWER_DOWN_CTL] && wakeIrq) begin
      nxt_st.ctrl[BIT_IDLE_CTL] = 1'b0;
      events[IRQ_IDLE_EXIT]     = 1'b1;
    end

    // power-down sequence: stop oscillator, wake, wait for stable clock
    case (st_ff.phase)
      PH_RUN: begin
        if (st_ff.ctrl[BIT_POWER_DOWN_CTL]) begin
          nxt_st.phase = PH_DOWN;
        end
      end
      PH_DOWN: begin
        if (wakeIrq) begin
          nxt_st.phase     = PH_WARM;
          nxt_st.wakeStart = 1'b1;
          nxt_st.longCount = crystalOsc;
        end
      end
      PH_WARM: begin
        if (wk.done) begin
          nxt_st.phase                    = PH_RUN;
          nxt_st.ctrl[BIT_POWER_DOWN_CTL] = 1'b0;
          nxt_st.ctrl[BIT_IDLE_CTL]       = 1'b0;
          events[IRQ_DOWN_EXIT]           = 1'b1;
        end
      end
      default: begin
        nxt_st.phase = PH_RUN;
      end
    endcase

    // sticky status: a new event wins over a write-one clear
    nxt_st.irqStatus = nxt_st.irqStatus | events;

    // read data, unmapped addresses read zero
    nxt_st.rdData = 32'h0;
    if (req && !wb_we_i) begin
      if (hitCtrl) begin
        nxt_st.rdData = {24'h0, st_ff.ctrl};
      end else if (hitStatus) begin
        nxt_st.rdData = {29'h0, st_ff.irqStatus};
      end else if (hitMask) begin
        nxt_st.rdData = {29'h0, st_ff.irqMask};
      end
    end

    // output flops follow the next state so pins track the register at once
    nxt_st.baudDbl      = nxt_st.ctrl[BIT_BAUD_DOUBLE] && (serialMode != 2'h0);
    nxt_st.bit7FrameErr = nxt_st.ctrl[BIT_SERIAL_B7_SEL];
    nxt_st.idleOut      = nxt_st.ctrl[BIT_IDLE_CTL] && !nxt_st.ctrl[BIT_POWER_DOWN_CTL];
    nxt_st.downOut      = (nxt_st.phase != PH_RUN);
    nxt_st.oscOut  = (nxt_st.phase != PH_DOWN);
    nxt_st.holdOut = (nxt_st.phase != PH_RUN) || nxt_st.idleOut;
    nxt_st.irqOut  = |(nxt_st.irqStatus & nxt_st.irqMask);

    // synchronous reset: register value depends on the reset cause
    if (sys_rst) begin
      nxt_st           = '0;
      nxt_st.ctrl      = ctrlResetValue(resetCause);
      nxt_st.irqMask   = IRQ_MASK_RST;
      nxt_st.phase     = PH_RUN;
      nxt_st.oscOut    = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    st_ff <= nxt_st;
  end

  // ==========================================================================
  // outputs, all straight from flops
  assign wb_ack_o       = st_ff.ack;
  assign wb_dat_o       = st_ff.rdData;
  assign baudDouble     = st_ff.baudDbl;
  assign serialBit7IsFrameErr = st_ff.bit7FrameErr;
  assign idleMode             = st_ff.idleOut;
  assign powerDownMode        = st_ff.downOut;
  assign oscRun         = st_ff.oscOut;
  assign cpuHold        = st_ff.holdOut;
  assign irq            = st_ff.irqOut;
endmodule
`default_nettype wire

/* hw/wake_if.sv */
// handshake between the power control register and the start-up counter
`timescale 1ns/1ps
`default_nettype none
interface wake_if;
  logic start;
  logic longCount;
  logic done;

  modport requester (output start, output longCount, input done);
  modport counter   (input start, input longCount, output done);
endinterface
`default_nettype wire

/* tb/power_control_register_checker.sv */
// port-level assertions for the power control register
`timescale 1ns/1ps
`default_nettype none
module power_control_register_checker (
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       wb_we_i,
  input wire logic       wb_ack_o,
  input wire logic       wakeIrq,
  input wire logic       crystalOsc,
  input wire logic [1:0] serialMode,
  input wire logic       baudDouble,
  input wire logic       serialBit7IsFrameErr,
  input wire logic       idleMode,
  input wire logic       powerDownMode,
  input wire logic       oscRun,
  input wire logic       cpuHold
);
  localparam int XTAL_LIM = 1024;
  localparam int RC_LIM   = 256;
  logic [11:0] warmCnt_ff;
  logic [11:0] nxt_warmCnt;
  // ==========================================================================
  // warm-up length, counted only while the oscillator restarts in power-down
  always_comb nxt_warmCnt = (oscRun && powerDownMode) ? warmCnt_ff + 12'h001 : 12'h000;
  always_ff @(posedge ref_clk) begin
    warmCnt_ff <= sys_rst ? 12'h000 : nxt_warmCnt;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================================
  // assertions; a few cycles of slack because the exit path is registered
  a_baud_mode_zero: assert property (serialMode == 2'h0 && $past(serialMode) == 2'h0 |-> !baudDouble)
    else $error("baud doubled in serial mode 0");
  a_bit7_sel_write: assert property ($changed(serialBit7IsFrameErr) |-> $past(wb_we_i) || $past(wb_we_i, 2))
    else $error("bit7 select changed without a write");
  a_idle_entry: assert property ($rose(idleMode) |-> $past(wb_we_i) || $past(wb_we_i, 2))
    else $error("idle entered without a write");
  a_idle_exit: assert property (idleMode && wakeIrq |-> ##[1:2] !idleMode)
    else $error("idle not left on interrupt");
  a_hold_in_mode: assert property (idleMode || powerDownMode |-> cpuHold)
    else $error("cpu not held in a low power mode");
  a_down_entry: assert property ($rose(powerDownMode) |-> $past(wb_we_i) || $past(wb_we_i, 2) || $past(wb_we_i, 3))
    else $error("power-down entered without a write");
  a_osc_stop_down: assert property (!oscRun |-> powerDownMode)
    else $error("oscillator stopped outside power-down");
  a_warm_length: assert property ($fell(powerDownMode) |-> ($past(crystalOsc)
    ? (warmCnt_ff >= XTAL_LIM - 3 && warmCnt_ff <= XTAL_LIM + 3)
    : (warmCnt_ff >= RC_LIM - 3 && warmCnt_ff <= RC_LIM + 3)))
    else $error("wrong oscillator start-up length");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule
bind power_control_register power_control_register_checker power_control_register_checker_i (
  .ref_clk, .sys_rst, .wb_we_i, .wb_ack_o, .wakeIrq, .crystalOsc, .serialMode,
  .baudDouble, .serialBit7IsFrameErr, .idleMode, .powerDownMode, .oscRun, .cpuHold
);
`default_nettype wire

/* tb/power_control_register_test.sv */
// self-checking bench for the power control register
`timescale 1ns/1ps
`default_nettype none
module power_control_register_test;
  import power_control_pkg::*;
  logic         ref_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, brownoutEvent, wakeIrq, crystalOsc;
  logic [11:0]  wb_adr_i;
  logic [3:0]   wb_sel_i, wrSel;
  logic [31:0]  wb_dat_i, wb_dat_o;
  logic [1:0]   serialMode;
  logic         baudDouble, serialBit7IsFrameErr, idleMode, powerDownMode, oscRun, cpuHold, irq;
  reset_cause_e resetCause;
  logic [7:0]   rd;
  int           nErrors, numChecks, n;
  power_control_register power_control_register_i (.ref_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .resetCause, .brownoutEvent, .wakeIrq,
    .crystalOsc, .serialMode, .baudDouble, .serialBit7IsFrameErr, .idleMode, .powerDownMode, .oscRun, .cpuHold,
    .irq);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ==========================================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle; waits for ack however long it takes, watchdog ends a hang
  task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_sel_i <= wrSel;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
    xfer(a, 1'b0, 8'h00);
    check({24'h000000, rd}, {24'h000000, exp});
  endtask
  task automatic wait_clk(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    wait_clk(20000);
    nErrors++;
    give_verdict;
  end
  // ==========================================================================
  // main sequence; 0x21c control, 0x3c0 status, 0x3c4 mask
  initial begin
    {sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, brownoutEvent, wakeIrq, crystalOsc} = 7'h40;
    {wb_adr_i, wb_dat_i, serialMode, wb_sel_i} = '0;
    wb_sel_i = 4'hf;
    wrSel = 4'hf;
    resetCause = CAUSE_POWER_ON;
    nErrors = 0;
    numChecks = 0;
    wait_clk(10);
    sys_rst <= 1'b0;
    rdchk(12'h21c, 8'h30);
    xfer(12'h21c, 1'b1, 8'h1c);
    rdchk(12'h21c, 8'h1c);
    brownoutEvent <= 1'b1;
    wait_clk(1);
    brownoutEvent <= 1'b0;
    rdchk(12'h21c, 8'h3c);
    rdchk(12'h3c0, 8'h01);
    check(irq, 1'b0);
    xfer(12'h3c4, 1'b1, 8'h07);
    wait_clk(2);
    check(irq, 1'b1);
    xfer(12'h3c0, 1'b1, 8'h01);
    wait_clk(2);
    check(irq, 1'b0);
    // unmapped write must not disturb the stored flags
    xfer(12'h100, 1'b1, 8'hff);
    rdchk(12'h100, 8'h00);
    rdchk(12'h21c, 8'h3c);
    // a write with the low byte lane off is ignored
    wrSel = 4'he;
    xfer(12'h21c, 1'b1, 8'hff);
    wrSel = 4'hf;
    rdchk(12'h21c, 8'h3c);
    xfer(12'h21c, 1'b1, 8'hc0);
    for (int m = 0; m < 4; m++) begin
      serialMode <= m[1:0];
      wait_clk(3);
      check(baudDouble, m != 0);
    end
    check(serialBit7IsFrameErr, 1'b1);
    xfer(12'h21c, 1'b1, 8'h01);
    wait_clk(2);
    check({idleMode, cpuHold, serialBit7IsFrameErr}, 3'b110);
    wakeIrq <= 1'b1;
    wait_clk(3);
    check(idleMode, 1'b0);
    wakeIrq <= 1'b0;
    rdchk(12'h21c, 8'h00);
    rdchk(12'h3c0, 8'h02);
    xfer(12'h3c0, 1'b1, 8'h02);
    // power-down with both start-up lengths
    for (int x = 0; x < 2; x++) begin
      crystalOsc <= x[0];
      xfer(12'h21c, 1'b1, 8'h02);
      wait_clk(3);
      check({powerDownMode, oscRun, cpuHold}, 3'b101);
      wakeIrq <= 1'b1;
      n = 0;
      while (powerDownMode !== 1'b0) begin
        @(posedge ref_clk);
        n++;
      end
      wakeIrq <= 1'b0;
      check(n >= (x ? 1024 : 256) && n <= (x ? 1029 : 261), 1'b1);
      rdchk(12'h21c, 8'h00);
      rdchk(12'h3c0, 8'h04);
      xfer(12'h3c0, 1'b1, 8'h04);
    end
    // each reset cause, taken while idle
    for (int c = 0; c < 3; c++) begin
      xfer(12'h21c, 1'b1, 8'h0d);
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      resetCause <= reset_cause_e'(c[1:0]);
      wait_clk(2);
      sys_rst <= 1'b0;
      wait_clk(1);
      check(idleMode, 1'b0);
      rdchk(12'h21c, c == 1 ? 8'h30 : (c == 2 ? 8'h20 : 8'h00));
    end
    give_verdict;
  end
endmodule
`default_nettype wire
